/* File: common/spr_pkg.sv */
// Shared constants for the serial terminal parameter register block.
package spr_pkg;
  // ==========================================================
  // Register indices
  localparam logic [5:0] ADDR_THRESH = 6'h12;
  localparam logic [5:0] ADDR_UNLOCK = 6'h1f;
  localparam logic [5:0] ADDR_BAUD   = 6'h20;
  localparam logic [5:0] ADDR_FRAME  = 6'h21;
  localparam logic [5:0] ADDR_FEAT   = 6'h22;
  localparam logic [5:0] ADDR_LEN    = 6'h23;
  localparam logic [5:0] MFR_FIRST   = 6'h10;
  // ==========================================================
  // Reset values and the unlock key
  localparam logic [15:0] RST_THRESH = 16'h0080;
  localparam logic [15:0] RST_BAUD   = 16'h0006;
  localparam logic [15:0] RST_FRAME  = 16'h0003;
  localparam logic [15:0] RST_FEAT   = 16'h0003;
  localparam logic [15:0] RST_LEN    = 16'h0003;
  localparam logic [15:0] UNLOCK_KEY = 16'h1235;
  localparam logic [7:0]  CUSTOM_LB  = 8'hff;
  // ==========================================================
  // Control byte and feature bit positions
  localparam int CB_REG = 7;
  localparam int CB_WR  = 6;
  localparam int CB_SND = 3;
  localparam int CB_IR  = 2;
  localparam int FB_RTS = 0;
  localparam int FB_ALT = 1;
  localparam int FB_DLY = 2;
  localparam int FB_XTX = 3;
  localparam int FB_XRX = 4;
  localparam int FB_CNT = 6;
  // ==========================================================
  // Flow control characters and levels
  localparam logic [7:0] CH_XOFF = 8'h13;
  localparam logic [7:0] CH_XON  = 8'h11;
  localparam logic [7:0] LVL_HI  = 8'd118;
  localparam logic [7:0] LVL_LO  = 8'd18;
  // ==========================================================
  // Bit periods in clock cycles
  localparam int CLK_HZ = 25_000_000;
  localparam int CUST_HZ = 4_000_000;
  localparam logic [15:0] CYC_1200  = 16'(CLK_HZ / 1200);
  localparam logic [15:0] CYC_2400  = 16'(CLK_HZ / 2400);
  localparam logic [15:0] CYC_4800  = 16'(CLK_HZ / 4800);
  localparam logic [15:0] CYC_9600  = 16'(CLK_HZ / 9600);
  localparam logic [15:0] CYC_19200 = 16'(CLK_HZ / 19200);
  localparam logic [15:0] CYC_CUST  = 16'(16 * CLK_HZ / CUST_HZ);
  localparam int FIFO_DEPTH = 16;
endpackage

/* File: rtl/spr_param_regs.sv */
// Parameter registers, register access and flow control of a serial terminal.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Send buffer
module spr_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         flush,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wPtr_reg, rPtr_reg;
  logic [AW:0]   cnt_reg, cnt_next;
  logic          notFull_reg;
  wire doWr = inValid && notFull_reg;
  wire doRd = outReady && (cnt_reg != '0);
  assign inReady  = notFull_reg;
  assign outValid = cnt_reg != '0;
  assign outData  = mem[rPtr_reg];
  assign cnt_next = flush ? '0 : cnt_reg + (AW+1)'(doWr) - (AW+1)'(doRd);
  always_ff @(posedge clk) begin
    if (doWr) mem[wPtr_reg] <= inData;
  end
  always_ff @(posedge clk) begin
    if (srst || flush) begin
      wPtr_reg <= '0;
      rPtr_reg <= '0;
    end else begin
      wPtr_reg <= wPtr_reg + AW'(doWr);
      rPtr_reg <= rPtr_reg + AW'(doRd);
    end
    cnt_reg  <= srst ? '0 : cnt_next;
    notFull_reg <= srst || (cnt_next != (AW+1)'(D));
  end
endmodule

// Function
// - Manufacturer registers locked without unlock word
// - Parameter writes persisted to nonvolatile store
// - Buffer-full flag at threshold low byte
// - Key 0x1235 unlocks, other values lock
// - Unlock word reads back, zero when locked
// - Low byte 0xFF gives custom rate
// - Frame bits select data, parity, stops
// - Feature bit 0 enables RTS/CTS
// - Feature bit 1 selects output format
// - Feature bit 2 delays status byte
// - XOFF halts sending until XON
// - Send XOFF at 118, XON below 18
// - Rising control bit 3 sends buffer
// - Status bit 2 acknowledges, control bit 3 low clears
// - Mapped length 1..5 bytes, default 3
// - Control bit 7 selects register mode
// - Read returns value without change
// - Write stores data, acknowledged in status
// - Address from control bits 5..0
// - Status byte then two value bytes
// - Init blocks, flushes, reloads, acknowledges
// - Write acknowledge echoes address with bit 7
module spr_param_regs (
  input  wire logic        clk,
  input  wire logic        srst,
  // Output process image from the coupler
  input  wire logic        imageValid,
  input  wire logic [7:0]  ctrlByte,
  input  wire logic [7:0]  dataOutHi,
  input  wire logic [7:0]  dataOutLo,
  // Input process image to the coupler
  output logic [7:0]       statusByte,
  output logic [7:0]       dataInHi,
  output logic [7:0]       dataInLo,
  // Nonvolatile store write port
  output logic             nvWrite,
  output logic [5:0]       nvAddr,
  output logic [15:0]      nvData,
  // Active serial settings
  output logic [15:0]      bitPeriod,
  output logic             dataBits8,
  output logic             parityEn,
  output logic             parityOdd,
  output logic             twoStop,
  output logic             rtsCtsEn,
  output logic             altFormat,
  output logic [2:0]       mappedLen,
  output logic             serialBlocked,
  // Receiver side
  input  wire logic [7:0]  rxFillLevel,
  input  wire logic        rxCharValid,
  input  wire logic [7:0]  rxChar,
  output logic             bufFull,
  output logic             flowValid,
  output logic [7:0]       flowChar,
  // Send path
  input  wire logic        loadValid,
  output logic             loadReady,
  input  wire logic [7:0]  loadData,
  output logic             txValid,
  input  wire logic        txReady,
  output logic [7:0]       txData
);
  import spr_pkg::*;

  // ==========================================================
  // Stored registers and active copies
  logic [15:0] thresh_reg, unlock_reg, baud_reg, frame_reg, feat_reg, len_reg;
  logic [15:0] aThresh_reg, aBaud_reg, aFrame_reg, aFeat_reg, aLen_reg;
  logic [7:0]  status_reg, statusPipe_reg, dHi_reg, dLo_reg;
  logic        initAck_reg, sending_reg, contAck_reg, prevSnd_reg;
  logic        txHalt_reg, xoffSent_reg, flowValid_reg, bufFull_reg;
  logic [7:0]  flowChar_reg, txData_reg;
  logic        txValid_reg, nvWrite_reg;
  logic [5:0]  nvAddr_reg;
  logic [15:0] nvData_reg, bitPeriod_reg;

  // ==========================================================
  // Control byte decode
  wire       regMode  = imageValid && ctrlByte[CB_REG];
  wire [5:0] regIndex = ctrlByte[5:0];
  wire       isWrite  = regMode && ctrlByte[CB_WR];
  wire       isRead   = regMode && !ctrlByte[CB_WR];
  wire       pdMode   = imageValid && !ctrlByte[CB_REG];
  wire       initReq  = pdMode && ctrlByte[CB_IR];
  wire       sndBit   = pdMode && ctrlByte[CB_SND];
  wire       unlocked = unlock_reg == UNLOCK_KEY;
  wire       protArea = regIndex >= MFR_FIRST && regIndex != ADDR_UNLOCK;
  wire       wrOk     = isWrite && !(protArea && !unlocked);
  wire [15:0] wrVal   = {dataOutHi, dataOutLo};
  wire       wrThr    = wrOk && regIndex == ADDR_THRESH;
  wire       wrUnl    = isWrite && regIndex == ADDR_UNLOCK;
  wire       wrBaud   = wrOk && regIndex == ADDR_BAUD;
  wire       wrFrm    = wrOk && regIndex == ADDR_FRAME;
  wire       wrFeat   = wrOk && regIndex == ADDR_FEAT;
  wire       wrLen    = wrOk && regIndex == ADDR_LEN;
  wire       stored   = wrThr || wrBaud || wrFrm || wrFeat || wrLen;
  wire [15:0] unlRead = unlocked ? unlock_reg : 16'h0000;
  wire [15:0] rdVal   =
    (regIndex == ADDR_THRESH) ? thresh_reg :
    (regIndex == ADDR_UNLOCK) ? unlRead :
    (regIndex == ADDR_BAUD)   ? baud_reg :
    (regIndex == ADDR_FRAME)  ? frame_reg :
    (regIndex == ADDR_FEAT)   ? feat_reg :
    (regIndex == ADDR_LEN)    ? len_reg : 16'h0000;

  // ==========================================================
  // Register storage
  always_ff @(posedge clk) begin
    if (srst) begin
      thresh_reg <= RST_THRESH;
      unlock_reg <= 16'h0000;
      baud_reg   <= RST_BAUD;
      frame_reg  <= RST_FRAME;
      feat_reg   <= RST_FEAT;
      len_reg    <= RST_LEN;
    end else begin
      if (wrThr) thresh_reg <= wrVal;
      if (wrUnl) unlock_reg <= wrVal;
      if (wrBaud) baud_reg <= wrVal;
      if (wrFrm) frame_reg <= wrVal;
      if (wrFeat) feat_reg <= wrVal;
      if (wrLen) len_reg <= wrVal;
    end
  end

  // The unlock word lives in RAM only, so it is never persisted.
  always_ff @(posedge clk) begin
    nvWrite_reg <= !srst && stored;
    if (stored) {nvAddr_reg, nvData_reg} <= {regIndex, wrVal};
  end

  // ==========================================================
  // Init request: settings take effect only when reloaded here
  always_ff @(posedge clk) begin
    if (srst) begin
      aThresh_reg <= RST_THRESH;
      aBaud_reg   <= RST_BAUD;
      aFrame_reg  <= RST_FRAME;
      aFeat_reg   <= RST_FEAT;
      aLen_reg    <= RST_LEN;
      initAck_reg <= 1'b0;
    end else if (initReq) begin
      aThresh_reg <= thresh_reg;
      aBaud_reg   <= baud_reg;
      aFrame_reg  <= frame_reg;
      aFeat_reg   <= feat_reg;
      aLen_reg    <= len_reg;
      initAck_reg <= 1'b1;
    end else if (pdMode) begin
      initAck_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Setting decode
  wire [2:0] bCode = aBaud_reg[2:0];
  wire [15:0] custCyc = 16'(CYC_CUST * (aBaud_reg[15:8] + 9'd1));
  wire [15:0] stdCyc =
    (bCode == 3'b011) ? CYC_1200 :
    (bCode == 3'b100) ? CYC_2400 :
    (bCode == 3'b101) ? CYC_4800 :
    (bCode == 3'b111) ? CYC_19200 : CYC_9600;
  wire custom = aBaud_reg[7:0] == CUSTOM_LB;
  wire [2:0] fCode = aFrame_reg[2:0];
  wire [7:0] lenLo = aLen_reg[7:0];
  wire [2:0] lenClip = (lenLo == 8'd0) ? 3'd1 : (lenLo > 8'd5) ? 3'd5 : lenLo[2:0];

  always_ff @(posedge clk) begin
    bitPeriod_reg <= custom ? custCyc : stdCyc;
    bufFull_reg   <= !srst && rxFillLevel >= aThresh_reg[7:0];
    dataBits8     <= fCode >= 3'b011;
    parityEn      <= fCode != 3'b011;
    parityOdd     <= fCode == 3'b010 || fCode == 3'b101;
    mappedLen     <= lenClip;
  end

  // ==========================================================
  // Flow control
  wire xTx = aFeat_reg[FB_XTX];
  wire xRx = aFeat_reg[FB_XRX];
  wire needXoff = xRx && !xoffSent_reg && rxFillLevel >= LVL_HI;
  wire needXon  = xoffSent_reg && rxFillLevel < LVL_LO;
  always_ff @(posedge clk) begin
    if (srst || initReq) begin
      txHalt_reg    <= 1'b0;
      xoffSent_reg  <= 1'b0;
      flowValid_reg <= 1'b0;
      flowChar_reg  <= 8'h00;
    end else begin
      if (rxCharValid && xTx && rxChar == CH_XOFF) txHalt_reg <= 1'b1;
      else if (rxCharValid && rxChar == CH_XON) txHalt_reg <= 1'b0;
      flowValid_reg <= needXoff || needXon;
      if (needXoff) begin
        flowChar_reg <= CH_XOFF;
        xoffSent_reg <= 1'b1;
      end else if (needXon) begin
        flowChar_reg <= CH_XON;
        xoffSent_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Send path with continuous-send mode
  wire       fOutValid;
  wire [7:0] fOutData;
  wire       contMode = aFeat_reg[FB_CNT];
  wire       canGo = !txHalt_reg && !initReq && (!contMode || sending_reg);
  wire       take  = canGo && (!txValid_reg || txReady);
  wire       sndRise = sndBit && !prevSnd_reg;
  wire       sendDone = sending_reg && !fOutValid && (!txValid_reg || txReady);

  spr_fifo #(.W(8), .D(FIFO_DEPTH)) sendBuf (
    .clk      (clk),
    .srst     (srst),
    .flush    (initReq),
    .inValid  (loadValid),
    .inReady  (loadReady),
    .inData   (loadData),
    .outValid (fOutValid),
    .outReady (take),
    .outData  (fOutData)
  );

  always_ff @(posedge clk) begin
    if (srst || initReq) begin
      txValid_reg <= 1'b0;
      sending_reg <= 1'b0;
      contAck_reg <= 1'b0;
      prevSnd_reg <= 1'b0;
    end else begin
      if (take) txValid_reg <= fOutValid;
      else if (txReady) txValid_reg <= 1'b0;
      if (imageValid) prevSnd_reg <= sndBit;
      if (contMode && sndRise) sending_reg <= 1'b1;
      else if (sendDone) sending_reg <= 1'b0;
      // The acknowledge set wins over a clear in the same cycle.
      if (sendDone && contMode) contAck_reg <= 1'b1;
      else if (pdMode && !ctrlByte[CB_SND]) contAck_reg <= 1'b0;
    end
    if (take && fOutValid) txData_reg <= fOutData;
  end

  // ==========================================================
  // Input image
  wire [7:0] pdStatus = {4'h0, bufFull_reg, initAck_reg | contAck_reg, 2'b00};
  wire [7:0] rgStatus = {1'b1, 1'b0, regIndex};
  wire [7:0] sNext = regMode ? rgStatus : pdStatus;
  always_ff @(posedge clk) begin
    if (srst) begin
      {statusPipe_reg, status_reg, dHi_reg, dLo_reg} <= 32'h0000_0000;
    end else begin
      statusPipe_reg <= sNext;
      status_reg <= aFeat_reg[FB_DLY] ? statusPipe_reg : sNext;
      if (isRead) {dHi_reg, dLo_reg} <= rdVal;
      else if (isWrite) {dHi_reg, dLo_reg} <= 16'h0000;
    end
  end

  assign statusByte = status_reg;
  assign dataInHi = dHi_reg;
  assign dataInLo = dLo_reg;
  assign nvWrite = nvWrite_reg;
  assign nvAddr = nvAddr_reg;
  assign nvData = nvData_reg;
  assign bitPeriod = bitPeriod_reg;
  assign twoStop = aFrame_reg[3];
  assign rtsCtsEn = aFeat_reg[FB_RTS];
  assign altFormat = aFeat_reg[FB_ALT];
  assign serialBlocked = initAck_reg;
  assign bufFull = bufFull_reg;
  assign flowValid = flowValid_reg;
  assign flowChar = flowChar_reg;
  assign txValid = txValid_reg;
  assign txData = txData_reg;

  // ==========================================================
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  lock_write_a: assert property (
    wrThr == 1'b0 && isWrite && regIndex == ADDR_THRESH |=> $stable(thresh_reg))
    else $error("Locked threshold write changed the register.");
  unlock_read_a: assert property (
    isRead && regIndex == ADDR_UNLOCK
    |=> {dataInHi, dataInLo} == (unlocked ? UNLOCK_KEY : 16'h0000))
    else $error("Unlock word read back wrong.");
  buf_full_a: assert property (
    rxFillLevel >= aThresh_reg[7:0] && $stable(aThresh_reg) |=> bufFull)
    else $error("Buffer-full flag missing at threshold.");
  baud_cust_a: assert property (
    custom && $stable(aBaud_reg) |=> bitPeriod == 16'(CYC_CUST * ($past(aBaud_reg[15:8]) + 9'd1)))
    else $error("Custom bit period wrong.");
  xoff_halt_a: assert property (
    rxCharValid && xTx && rxChar == CH_XOFF && !initReq |=> txHalt_reg ##0 !take)
    else $error("XOFF did not halt sending.");
  xoff_send_a: assert property (
    needXoff && !initReq |=> flowValid && flowChar == CH_XOFF)
    else $error("XOFF not sent at high level.");
  write_ack_a: assert property (
    isWrite && !aFeat_reg[FB_DLY] |=> statusByte == {2'b10, $past(regIndex)})
    else $error("Write acknowledge wrong.");
  status_dly_a: assert property (
    isWrite && aFeat_reg[FB_DLY] ##1 aFeat_reg[FB_DLY]
    |=> statusByte == {2'b10, $past(regIndex, 2)})
    else $error("Delayed write acknowledge wrong.");
  read_keep_a: assert property (
    isRead && !isWrite |=> $stable(feat_reg) && $stable(baud_reg))
    else $error("Read altered a register.");
  init_ack_a: assert property (
    initReq |=> serialBlocked && aBaud_reg == $past(baud_reg) && !txValid)
    else $error("Init did not reload and acknowledge.");
  cover_write_c: cover property (isWrite ##1 nvWrite);
  cover_cont_c: cover property (sndRise && contMode ##[1:40] contAck_reg);
  cover_xon_c: cover property (flowValid && flowChar == CH_XON);
endmodule

`default_nettype wire

/* File: bench/spr_tx_partner.sv */
// Serial transmitter stand-in that takes bytes from the send path.
`timescale 1ns/1ps
`default_nettype none
module spr_tx_partner (
  // Clock
  input  wire logic       clk,
  // Byte stream from the block
  input  wire logic       txValid,
  input  wire logic [7:0] txData,
  output logic            txReady,
  // Pacing chosen by the bench
  input  wire logic       slow
);
  logic [7:0] got [$];
  logic       phase = 1'b0;
  initial txReady = 1'b0;
  // ==========
  // A slow line takes a byte only every other cycle, like a busy shifter.
  always @(negedge clk) begin
    phase   <= ~phase;
    txReady <= ~slow | phase;
  end
  always @(posedge clk) begin
    if (txValid === 1'b1 && txReady === 1'b1) begin
      got.push_back(txData);
    end
  end
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking bench for the serial terminal parameter registers.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import spr_pkg::*;
  // ==========
  // Stimulus and observed signals
  logic        clk         = 1'b0;
  logic        srst        = 1'b1;
  logic        imageValid  = 1'b0;
  logic [7:0]  ctrlByte    = 8'h00;
  logic [7:0]  dataOutHi   = 8'h00;
  logic [7:0]  dataOutLo   = 8'h00;
  logic [7:0]  rxFillLevel = 8'h00;
  logic        rxCharValid = 1'b0;
  logic [7:0]  rxChar      = 8'h00;
  logic        loadValid   = 1'b0;
  logic [7:0]  loadData    = 8'h00;
  logic        slow        = 1'b0;
  logic [7:0]  statusByte, dataInHi, dataInLo, flowChar, txData;
  logic [5:0]  nvAddr;
  logic [15:0] nvData, bitPeriod;
  logic [2:0]  mappedLen;
  logic        nvWrite, dataBits8, parityEn, parityOdd, twoStop, rtsCtsEn, altFormat;
  logic        serialBlocked, bufFull, flowValid, loadReady, txValid, txReady;
  int          num_errors  = 0;
  int          cmp_count   = 0;
  int          cycles      = 0;
  int          nvCount     = 0;
  logic [21:0] nvLast      = 22'h00_0000;
  logic [7:0]  imgStat     = 8'h00;
  logic        dlyOn       = 1'b0;

  spr_param_regs dut (.clk, .srst, .imageValid, .ctrlByte, .dataOutHi, .dataOutLo,
    .statusByte, .dataInHi, .dataInLo, .nvWrite, .nvAddr, .nvData, .bitPeriod,
    .dataBits8, .parityEn, .parityOdd, .twoStop, .rtsCtsEn, .altFormat, .mappedLen,
    .serialBlocked, .rxFillLevel, .rxCharValid, .rxChar, .bufFull, .flowValid,
    .flowChar, .loadValid, .loadReady, .loadData, .txValid, .txReady, .txData);
  spr_tx_partner p (.clk, .txValid, .txData, .txReady, .slow);

  always #20 clk = ~clk;

  // ==========
  // Persisted-write log and hang guard
  always @(negedge clk) begin
    cycles++;
    if (nvWrite === 1'b1) begin
      nvCount++;
      nvLast = {nvAddr, nvData};
    end
    if (cycles == 40000) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // ==========
  // Process image cycles
  // The register answer in the status byte stands one cycle only, one edge later if delayed.
  task automatic img(input logic [7:0] c, input logic [15:0] v);
    @(negedge clk);
    imageValid = 1'b1;
    ctrlByte = c;
    {dataOutHi, dataOutLo} = v;
    @(negedge clk);
    imageValid = 1'b0;
    imgStat = statusByte;
    @(negedge clk);
    if (dlyOn) imgStat = statusByte;
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] v);
    img({2'b11, a}, v);
    chk("write ack", 16'({2'b10, a}), 16'(imgStat));
    chk("write echo", 16'h0000, {dataInHi, dataInLo});
  endtask

  task automatic rd(input logic [5:0] a, input logic [15:0] exp);
    img({2'b10, a}, 16'ha5a5);
    chk("read status", 16'({2'b10, a}), 16'(imgStat));
    chk("read value", exp, {dataInHi, dataInLo});
  endtask

  task automatic init_port();
    img(8'h04, 16'h0000);
    @(negedge clk);
    chk("init blocked", 16'h0001, 16'(serialBlocked));
    chk("init status", 16'h0004, 16'(statusByte & 8'h04));
    img(8'h00, 16'h0000);
    chk("init released", 16'h0000, 16'(serialBlocked));
  endtask

  task automatic push(input logic [7:0] b, output bit ok);
    @(negedge clk);
    loadValid = 1'b1;
    loadData = b;
    @(posedge clk);
    ok = (loadReady === 1'b1);
    @(negedge clk);
    loadValid = 1'b0;
  endtask

  task automatic rxc(input logic [7:0] c);
    @(negedge clk);
    rxCharValid = 1'b1;
    rxChar = c;
    @(negedge clk);
    rxCharValid = 1'b0;
  endtask

  task automatic see_flow(input logic [7:0] exp);
    logic [7:0] seen;
    seen = 8'h00;
    repeat (8) begin
      @(negedge clk);
      if (flowValid === 1'b1) begin
        seen = flowChar;
      end
    end
    chk("flow char", 16'(exp), 16'(seen));
  endtask

  // ==========
  // Scenarios
  task automatic t_defaults();
    rd(ADDR_THRESH, RST_THRESH);
    rd(ADDR_BAUD, RST_BAUD);
    rd(ADDR_FRAME, RST_FRAME);
    rd(ADDR_FEAT, RST_FEAT);
    rd(ADDR_LEN, RST_LEN);
    rd(ADDR_UNLOCK, 16'h0000);
    rd(6'h3e, 16'h0000);
    chk("bit period", CYC_9600, bitPeriod);
    chk("frame flags", 16'h0008, 16'({dataBits8, parityEn, parityOdd, twoStop}));
    chk("feature flags", 16'h0003, 16'({rtsCtsEn, altFormat}));
    $display("defaults test done");
  endtask

  task automatic t_protect();
    wr(ADDR_BAUD, 16'h0004);
    rd(ADDR_BAUD, RST_BAUD);
    chk("persisted writes", 16'h0000, 16'(nvCount));
    wr(ADDR_UNLOCK, UNLOCK_KEY);
    rd(ADDR_UNLOCK, UNLOCK_KEY);
    wr(ADDR_BAUD, 16'h0004);
    rd(ADDR_BAUD, 16'h0004);
    rd(ADDR_BAUD, 16'h0004);
    chk("persisted writes", 16'h0001, 16'(nvCount));
    chk("persisted address", 16'(ADDR_BAUD), 16'(nvLast[21:16]));
    chk("persisted value", 16'h0004, nvLast[15:0]);
    init_port();
    chk("bit period", CYC_2400, bitPeriod);
    $display("protection test done");
  endtask

  task automatic t_settings();
    logic [15:0] per [5] = '{CYC_1200, CYC_2400, CYC_4800, CYC_9600, CYC_19200};
    logic [3:0]  frm [5] = '{4'h5, 4'h6, 4'h9, 4'hc, 4'hf};
    for (int i = 1; i <= 5; i++) begin
      wr(ADDR_BAUD, 16'(i + 2));
      wr(ADDR_FRAME, 16'(i | ((i & 1) << 3)));
      wr(ADDR_LEN, 16'(i));
      init_port();
      chk("bit period", per[i-1], bitPeriod);
      chk("frame flags", 16'(frm[i-1]), 16'({dataBits8, parityEn, parityOdd, twoStop}));
      chk("mapped length", 16'(i), 16'(mappedLen));
    end
    wr(ADDR_BAUD, 16'h03ff);
    init_port();
    chk("custom period", 16'(CYC_CUST * 4), bitPeriod);
    wr(ADDR_UNLOCK, 16'h1234);
    rd(ADDR_UNLOCK, 16'h0000);
    wr(ADDR_THRESH, 16'h0011);
    rd(ADDR_THRESH, RST_THRESH);
    wr(ADDR_FRAME, 16'h0003);
    rd(ADDR_FRAME, 16'h000d);
    wr(ADDR_UNLOCK, UNLOCK_KEY);
    $display("settings test done");
  endtask

  task automatic t_threshold();
    wr(ADDR_THRESH, 16'hab20);
    init_port();
    rxFillLevel = 8'h1f;
    repeat (3) @(negedge clk);
    chk("buffer full", 16'h0000, 16'(bufFull));
    rxFillLevel = 8'h20;
    repeat (3) @(negedge clk);
    chk("buffer full", 16'h0001, 16'(bufFull));
    img(8'h00, 16'h0000);
    chk("status full bit", 16'h0008, 16'(statusByte & 8'h08));
    rxFillLevel = 8'h00;
    wr(ADDR_FEAT, 16'h0010);
    init_port();
    chk("feature flags", 16'h0000, 16'({rtsCtsEn, altFormat}));
    rxFillLevel = 8'h75;
    see_flow(8'h00);
    rxFillLevel = 8'h76;
    see_flow(CH_XOFF);
    rxFillLevel = 8'h12;
    see_flow(8'h00);
    rxFillLevel = 8'h11;
    see_flow(CH_XON);
    $display("threshold and flow test done");
  endtask

  task automatic t_xoff();
    int n0;
    bit ok;
    wr(ADDR_FEAT, 16'h000c);
    init_port();
    dlyOn = 1'b1;
    rd(ADDR_FEAT, 16'h000c);
    rxc(CH_XOFF);
    n0 = p.got.size();
    push(8'h41, ok);
    push(8'h42, ok);
    repeat (20) @(negedge clk);
    chk("bytes while held", 16'(n0), 16'(p.got.size()));
    rxc(CH_XON);
    repeat (20) @(negedge clk);
    chk("bytes after resume", 16'(n0 + 2), 16'(p.got.size()));
    chk("last byte", 16'h0042, 16'(p.got[n0 + 1]));
    $display("xoff test done");
  endtask

  task automatic t_continuous();
    int n0;
    int i;
    bit ok;
    wr(ADDR_FEAT, 16'h0040);
    init_port();
    dlyOn = 1'b0;
    slow = 1'b1;
    n0 = p.got.size();
    ok = 1'b1;
    for (i = 0; ok && i < 20; i++) begin
      push(8'h60 + 8'(i), ok);
    end
    chk("send buffer depth", 16'(FIFO_DEPTH), 16'(i - 1));
    repeat (10) @(negedge clk);
    chk("bytes before trigger", 16'(n0), 16'(p.got.size()));
    img(8'h08, 16'h0000);
    for (i = 0; i < 200 && p.got.size() < n0 + 16; i++) begin
      @(negedge clk);
    end
    repeat (4) @(negedge clk);
    chk("bytes after trigger", 16'(n0 + 16), 16'(p.got.size()));
    for (i = 0; i < 16; i++) begin
      chk("sent byte", 16'(8'h60 + i), 16'(p.got[n0 + i]));
    end
    chk("transfer ack", 16'h0004, 16'(statusByte & 8'h04));
    img(8'h00, 16'h0000);
    chk("transfer ack cleared", 16'h0000, 16'(statusByte & 8'h04));
    slow = 1'b0;
    $display("continuous send test done");
  endtask

  initial begin
    repeat (16) @(negedge clk);
    srst = 1'b0;
    t_defaults();
    t_protect();
    t_settings();
    t_threshold();
    t_xoff();
    t_continuous();
    give_verdict();
  end
endmodule
`default_nettype wire
